// ===== common/ocs_pkg.sv
package ocs_pkg;
  // clock and settling delay
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned SETTLE_MS   = 1000;
  localparam int unsigned SETTLE_CYC  = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int unsigned CNT_W       = 26;
  // register byte offsets
  localparam logic [11:0] OFF_CMD     = 12'h000;
  localparam logic [11:0] OFF_STB     = 12'h004;
  localparam logic [11:0] OFF_ESE     = 12'h008;
  localparam logic [11:0] OFF_ESR     = 12'h00c;
  localparam logic [11:0] OFF_SRE     = 12'h010;
  localparam logic [11:0] OFF_OQ      = 12'h014;
  localparam logic [11:0] OFF_ERRQ    = 12'h018;
  localparam logic [11:0] OFF_SYNC    = 12'h01c;
  localparam logic [11:0] OFF_EVT     = 12'h020;
  localparam logic [11:0] OFF_LOG     = 12'h040;
  // command codes in cmd[2:0]
  localparam logic [2:0]  CMD_OPC     = 3'h1;
  localparam logic [2:0]  CMD_OPCQ    = 3'h2;
  localparam logic [2:0]  CMD_WAI     = 3'h3;
  localparam logic [2:0]  CMD_CLS     = 3'h4;
  // event register indices
  localparam int unsigned NEVT        = 8;
  localparam int unsigned EVT_HW1     = 0;
  localparam int unsigned EVT_HW2     = 1;
  localparam int unsigned EVT_QUES    = 2;
  localparam int unsigned EVT_STD     = 3;
  localparam int unsigned EVT_OPER    = 4;
  localparam int unsigned EVT_CAL     = 5;
  localparam int unsigned EVT_COMM    = 6;
  localparam int unsigned EVT_CALLP   = 7;
  // bit positions, service request mask and '1' response byte
  localparam int unsigned ESR_OPC_BIT = 0;
  localparam int unsigned STB_HW      = 0;
  localparam int unsigned STB_MISC    = 1;
  localparam int unsigned STB_ERR     = 2;
  localparam int unsigned STB_QUES    = 3;
  localparam int unsigned STB_MAV     = 4;
  localparam int unsigned STB_ESB     = 5;
  localparam int unsigned STB_RQS     = 6;
  localparam int unsigned STB_OPER    = 7;
  localparam logic [7:0]  SRQ_MASK    = 8'hbf;
  localparam logic [7:0]  OQ_ONE      = 8'h31;
  // sizes
  localparam int unsigned NMEAS       = 4;
  localparam int unsigned ERRQ_DEPTH  = 4;
  localparam int unsigned LOG_W       = 16;

  typedef struct packed {
    logic [NMEAS-1:0] on;
    logic [NMEAS-1:0] awaited;
    logic [NMEAS-1:0] done;
  } ocs_meas_s;

  typedef enum logic [1:0] {
    SY_IDLE = 2'b01,
    SY_WAIT = 2'b10
  } ocs_sync_e;
endpackage

// ===== hw/ocs_sync_clear.sv
`timescale 1ns/1ps
// Contract
// [R1] opc query loads '1' only after completion
// [R2] loaded response sets message available bit
// [R3] each sync command starts one second delay
// [R4] request done from active measurements meanwhile
// [R5] satisfied only when delay and measurements done
// [R6] awaited measurement off keeps command pending
// [R7] controller avoids sync after call states
// [R8] queue read withheld while bit 4 clear
// [R9] bus held off until response available
// [R10] controller puts opc query last
// [R11] bit 4 set: service request on available
// [R12] wait command suspends later commands
// [R13] wait after call state blocks forever
// [R14] clear status zeroes all event registers
// [R15] clear empties error queue, keeps output
// [R16] clear drops status byte bits except bit 4, and service request
// [R17] clear keeps message log, reset only
// [R18] enable registers read and written, event registers read
// [R19] opc command sets event bit 0
// [R20] enable bit 5 routes standard events
// [R21] delay counter reloads per sync command
module ocs_sync_clear
  import ocs_pkg::*;
#(
  parameter int unsigned SETTLE_CYC_P = SETTLE_CYC
) (
  // apb slave
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // instrument side
  input  wire ocs_meas_s                 meas,
  input  wire logic                      ops_busy,
  input  wire logic [NEVT-1:0][7:0]      evt_set,
  input  wire logic                      err_push,
  input  wire logic [7:0]                err_code,
  input  wire logic                      log_push,
  // status and control out
  output logic                           meas_req,
  output logic                           cmd_hold,
  output logic                           srq
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  logic [31:0]            prdata_r;
  logic                   pready_r, pslverr_r, meas_req_r, cmd_hold_r, srq_r;
  ocs_sync_e              state_r;
  logic [CNT_W-1:0]       settle_cnt_r;
  logic                   opc_pend_r, opcq_pend_r, wai_pend_r, oq_valid_r;
  logic [NMEAS-1:0]       seen_r;
  logic [7:0]             oq_data_r, ese_r, sre_r;
  logic [NEVT-1:0][7:0]   evt_r;
  logic [7:0]             errq_mem_r [ERRQ_DEPTH];
  logic [1:0]             errq_wr_r, errq_rd_r;
  logic [2:0]             errq_cnt_r;
  logic [LOG_W-1:0]       log_cnt_r;
  logic                   acc, wr, rd, cmd_wr, is_sync, cls, stall, mapped;
  logic                   meas_ok, satisfied, opc_set, esr_rd, oq_pop, err_pop;
  logic [7:0]             stb;
  logic [31:0]            rdata;

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign meas_req = meas_req_r;
  assign cmd_hold = cmd_hold_r;
  assign srq      = srq_r;

  // bus decode
  assign acc     = psel & penable & ~pready_r;
  assign wr      = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign rd      = psel & penable & pready_r & ~pwrite & ~pslverr_r;
  assign cmd_wr  = wr & hit(paddr, OFF_CMD);
  assign is_sync = cmd_wr & ((pwdata[2:0] == CMD_OPC) |
                             (pwdata[2:0] == CMD_OPCQ) |
                             (pwdata[2:0] == CMD_WAI));
  assign cls     = cmd_wr & (pwdata[2:0] == CMD_CLS);
  assign esr_rd  = rd & hit(paddr, OFF_ESR);
  assign oq_pop  = rd & hit(paddr, OFF_OQ);
  assign err_pop = rd & hit(paddr, OFF_ERRQ) & (errq_cnt_r != 3'h0);
  // withheld response and suspended commands hold the access phase
  assign stall = (~pwrite & hit(paddr, OFF_OQ) & ~oq_valid_r &
                  ~sre_r[STB_MAV]) |                         // R8 R9
                 (pwrite & hit(paddr, OFF_CMD) & wai_pend_r); // R12 R13
  assign mapped = hit(paddr, OFF_CMD) | hit(paddr, OFF_STB) |
                  hit(paddr, OFF_ESE) | hit(paddr, OFF_ESR) |
                  hit(paddr, OFF_SRE) | hit(paddr, OFF_OQ) |
                  hit(paddr, OFF_ERRQ) | hit(paddr, OFF_SYNC) |
                  hit(paddr, OFF_LOG) |
                  ((paddr[11:5] == OFF_EVT[11:5]) && (paddr[1:0] == 2'h0));

  // completion condition
  assign meas_ok   = &(~meas.awaited |
                       (meas.on & (seen_r | meas.done)));  // R4 R6
  assign satisfied = (state_r == SY_WAIT) & (settle_cnt_r == '0) &
                     meas_ok & ~ops_busy & ~is_sync;      // R5
  assign opc_set   = satisfied & opc_pend_r;

  // status byte summary
  always_comb begin
    stb           = 8'h00;
    stb[STB_HW]   = |{evt_r[EVT_HW1], evt_r[EVT_HW2]};
    stb[STB_MISC] = |{evt_r[EVT_CAL], evt_r[EVT_COMM], evt_r[EVT_CALLP]};
    stb[STB_ERR]  = errq_cnt_r != 3'h0;
    stb[STB_QUES] = |evt_r[EVT_QUES];
    stb[STB_MAV]  = oq_valid_r;                            // R2
    stb[STB_ESB]  = |(evt_r[EVT_STD] & ese_r);
    stb[STB_RQS]  = srq_r;
    stb[STB_OPER] = |evt_r[EVT_OPER];
  end

  // read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(paddr, OFF_STB)) begin
      rdata[7:0] = stb;
    end else if (hit(paddr, OFF_ESE)) begin
      rdata[7:0] = ese_r;                                  // R18
    end else if (hit(paddr, OFF_ESR)) begin
      rdata[7:0] = evt_r[EVT_STD];                         // R18
    end else if (hit(paddr, OFF_SRE)) begin
      rdata[7:0] = sre_r;                                  // R18
    end else if (hit(paddr, OFF_OQ)) begin
      rdata[8:0] = {oq_valid_r, oq_data_r};
    end else if (hit(paddr, OFF_ERRQ)) begin
      rdata[8:0] = {errq_cnt_r != 3'h0, errq_mem_r[errq_rd_r]};
    end else if (hit(paddr, OFF_SYNC)) begin
      rdata[5:0] = {settle_cnt_r == '0, state_r == SY_WAIT,
                    wai_pend_r, opcq_pend_r, opc_pend_r, ops_busy};
    end else if (hit(paddr, OFF_LOG)) begin
      rdata[LOG_W-1:0] = log_cnt_r;
    end else if (paddr[11:5] == OFF_EVT[11:5]) begin
      rdata[7:0] = evt_r[paddr[4:2]];
    end
  end

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (acc && !(mapped && stall)) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~mapped;
      prdata_r  <= mapped ? rdata : 32'h0000_0000;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // sync state machine and settling counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= SY_IDLE;
      settle_cnt_r <= '0;
      opc_pend_r   <= 1'b0;
      opcq_pend_r  <= 1'b0;
      wai_pend_r   <= 1'b0;
      seen_r       <= '0;
    end else if (is_sync) begin
      state_r      <= SY_WAIT;                             // R3
      settle_cnt_r <= CNT_W'(SETTLE_CYC_P - 1);            // R21
      seen_r       <= '0;
      opc_pend_r   <= opc_pend_r | (pwdata[2:0] == CMD_OPC);
      opcq_pend_r  <= opcq_pend_r | (pwdata[2:0] == CMD_OPCQ);
      wai_pend_r   <= wai_pend_r | (pwdata[2:0] == CMD_WAI);
    end else begin
      unique case (state_r)
        SY_IDLE: seen_r <= '0;
        SY_WAIT: begin
          if (settle_cnt_r != '0) begin
            settle_cnt_r <= settle_cnt_r - CNT_W'(1);      // R21
          end
          seen_r <= seen_r | (meas.done & meas.on);        // R4
          if (satisfied) begin
            state_r     <= SY_IDLE;                        // R5
            opc_pend_r  <= 1'b0;
            opcq_pend_r <= 1'b0;
            wai_pend_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  // measurement request and command suspension levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_req_r <= 1'b0;
      cmd_hold_r <= 1'b0;
    end else begin
      meas_req_r <= is_sync | ((state_r == SY_WAIT) & ~satisfied); // R4
      cmd_hold_r <= (is_sync & (pwdata[2:0] == CMD_WAI)) |
                    (wai_pend_r & ~satisfied);             // R12
    end
  end

  // output queue, cls leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oq_valid_r <= 1'b0;
      oq_data_r  <= 8'h00;
    end else if (satisfied && opcq_pend_r) begin
      oq_valid_r <= 1'b1;                                  // R1 R2
      oq_data_r  <= OQ_ONE;                                // R1
    end else if (oq_pop) begin
      oq_valid_r <= 1'b0;                                  // R15
    end
  end

  // event registers, set wins over clear
  for (genvar i = 0; i < NEVT; i++) begin : g_evt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        evt_r[i] <= 8'h00;
      end else begin
        evt_r[i] <= ((cls || (esr_rd && i == EVT_STD)) ? 8'h00 : evt_r[i])
                    | evt_set[i]                           // R14
                    | ((i == EVT_STD && opc_set) ?
                       8'(1 << ESR_OPC_BIT) : 8'h00);      // R19
      end
    end
  end

  // enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ese_r <= 8'h00;
      sre_r <= 8'h00;
    end else begin
      if (wr && hit(paddr, OFF_ESE)) begin
        ese_r <= pwdata[7:0];                              // R18
      end
      if (wr && hit(paddr, OFF_SRE)) begin
        sre_r <= pwdata[7:0] & SRQ_MASK;                   // R18
      end
    end
  end

  // error queue, emptied by cls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errq_wr_r  <= 2'h0;
      errq_rd_r  <= 2'h0;
      errq_cnt_r <= 3'h0;
    end else if (cls) begin
      errq_rd_r  <= errq_wr_r;                             // R15
      errq_wr_r  <= errq_wr_r + 2'(err_push);
      errq_cnt_r <= {2'h0, err_push};
    end else begin
      if (err_pop) begin
        errq_rd_r <= errq_rd_r + 2'h1;
      end
      if (err_push && errq_cnt_r != 3'(ERRQ_DEPTH)) begin
        errq_wr_r <= errq_wr_r + 2'h1;
      end
      errq_cnt_r <= errq_cnt_r
                    + 3'(err_push && errq_cnt_r != 3'(ERRQ_DEPTH))
                    - 3'(err_pop);
    end
  end

  always_ff @(posedge pclk) begin
    if (err_push && (cls || errq_cnt_r != 3'(ERRQ_DEPTH))) begin
      errq_mem_r[errq_wr_r] <= err_code;
    end
  end

  // message log count, cleared only by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_cnt_r <= '0;                                     // R17
    end else if (log_push) begin
      log_cnt_r <= log_cnt_r + LOG_W'(1);
    end
  end

  // service request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srq_r <= 1'b0;
    end else if (cls) begin
      srq_r <= 1'b0;                                       // R16
    end else begin
      srq_r <= |(stb & sre_r & SRQ_MASK);                  // R11 R20
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence oq_wait_s;
    psel && penable && !pwrite && hit(paddr, OFF_OQ) &&
    !oq_valid_r && !sre_r[STB_MAV];
  endsequence

  sequence sync_done_s;
    (state_r == SY_WAIT) ##1 (state_r == SY_IDLE);
  endsequence

  opcq_load_a: assert property (satisfied && opcq_pend_r |=> // R1
    oq_valid_r && oq_data_r == OQ_ONE)
    else $error("completion response not loaded");
  oq_cause_a: assert property ($rose(oq_valid_r) |-> // R1
    $past(satisfied) && $past(opcq_pend_r))
    else $error("response loaded before completion");
  mav_bit_a: assert property (rd && hit(paddr, OFF_STB) |-> // R2
    prdata_r[STB_MAV] == $past(oq_valid_r))
    else $error("message available bit not set");
  settle_start_a: assert property (is_sync |=> // R3
    state_r == SY_WAIT && settle_cnt_r == CNT_W'(SETTLE_CYC_P - 1))
    else $error("settling delay not started");
  meas_req_a: assert property (state_r == SY_WAIT |-> meas_req_r) // R4
    else $error("measurement request missing");
  satisfy_cond_a: assert property (sync_done_s |-> // R5
    $past(settle_cnt_r) == '0 && $past(meas_ok) && !$past(ops_busy))
    else $error("sync finished early");
  off_never_a: assert property (state_r == SY_WAIT && // R6
    |(meas.awaited & ~meas.on) |-> !satisfied)
    else $error("completion with awaited measurement off");
  holdoff_a: assert property (oq_wait_s |=> !pready_r) // R8
    else $error("withheld response answered");
  holdoff_until_a: assert property (oq_wait_s ##1 oq_valid_r // R9
    && psel && penable |=> pready_r)
    else $error("holdoff not released");
  srq_mav_a: assert property (oq_valid_r && sre_r[STB_MAV] && // R11
    !cls |=> srq_r)
    else $error("no service request on message available");
  wai_hold_a: assert property (wai_pend_r && psel && penable && // R12
    pwrite && hit(paddr, OFF_CMD) && !satisfied |=> !pready_r && cmd_hold_r)
    else $error("command run during wait");
  cls_evt_a: assert property (cls && !opc_set |=> // R14
    evt_r == $past(evt_set))
    else $error("event registers not cleared");
  cls_queue_a: assert property (cls && !err_push |=> // R15
    errq_cnt_r == 3'h0 &&
    oq_valid_r == $past(oq_valid_r | (satisfied & opcq_pend_r)))
    else $error("queues wrong after clear");
  cls_srq_a: assert property (cls |=> !srq_r) // R16
    else $error("service request survived clear");
  log_keep_a: assert property (cls && !log_push |=> // R17
    log_cnt_r == $past(log_cnt_r))
    else $error("message log touched by clear");
  ese_write_a: assert property (wr && hit(paddr, OFF_ESE) |=> // R18
    ese_r == $past(pwdata[7:0]))
    else $error("enable write lost");
  opc_esr_a: assert property (opc_set |=> evt_r[EVT_STD][ESR_OPC_BIT]) // R19
    else $error("operation complete bit not set");
  esb_srq_a: assert property (stb[STB_ESB] && sre_r[STB_ESB] && // R20
    !cls |=> srq_r)
    else $error("standard event did not request service");

endmodule

// ===== tb/ocs_meas_model.sv
`timescale 1ns/1ps
module ocs_meas_model
  import ocs_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // request from the sync logic
  input  wire logic             meas_req,
  // behaviour setup
  input  wire logic [NMEAS-1:0] on_mask,
  input  wire logic [7:0]       dly,
  // measurement status
  output ocs_meas_s             meas
);
  logic [7:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
    end else if (!meas_req) begin
      cnt_r <= 8'h00;
    end else if (cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign meas.on      = on_mask;
  assign meas.awaited = 4'h3;
  // only measurements that are on answer, after dly cycles
  assign meas.done    = (meas_req && cnt_r >= dly) ? on_mask : '0;
endmodule

// ===== tb/opc_wai_sync_status_clear_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module opc_wai_sync_status_clear_tb;
  import ocs_pkg::*;
  localparam int unsigned SC = 20;
  logic                 pclk, presetn, psel, penable, pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, q;
  logic                 pready, pslverr, er, ops_busy, err_push, log_push;
  logic                 meas_req, cmd_hold, srq;
  logic [NEVT-1:0][7:0] evt_set;
  logic [7:0]           err_code, dly;
  logic [NMEAS-1:0]     on_mask;
  ocs_meas_s            meas;
  int                   fails, compares, cyc, t0, mn;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  ocs_sync_clear #(.SETTLE_CYC_P(SC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .ops_busy(ops_busy),
    .evt_set(evt_set), .err_push(err_push), .err_code(err_code),
    .log_push(log_push), .meas_req(meas_req), .cmd_hold(cmd_hold),
    .srq(srq));

  ocs_meas_model model (
    .pclk(pclk), .presetn(presetn), .meas_req(meas_req),
    .on_mask(on_mask), .dly(dly), .meas(meas));

  task summarize;
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task rst;
    @(posedge pclk);
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1) begin
      if (n == 400) begin
        fails++;
        $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        summarize();
      end
      n++;
      @(posedge pclk);
    end
    q = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; ops_busy = 0; err_push = 0; log_push = 0;
    evt_set = '0; err_code = '0; dly = 8'h05; on_mask = 4'h3;
    fails = 0; compares = 0; cyc = 0;
    rst();
    apb(0, OFF_STB, 0); `CHK(q, 32'h0)
    apb(1, OFF_ESE, 32'hff); apb(0, OFF_ESE, 0); `CHK(q, 32'hff)
    apb(1, OFF_SRE, 32'hff); apb(0, OFF_SRE, 0); `CHK(q, 32'hbf)
    apb(1, OFF_SRE, 0); apb(1, OFF_ESE, 0);
    apb(0, 12'hffc, 0);
    `CHK({er, q}, 33'h100000000)
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      dly <= i ? 8'h28 : 8'h05;
      mn = i ? 40 : SC;
      apb(1, OFF_CMD, {29'h0, CMD_OPCQ});
      t0 = cyc;
      tick(3); `CHK(meas_req, 1'b1)
      apb(0, OFF_OQ, 0); `CHK(q, 32'h131)
      `CHK((cyc - t0 >= mn) && (cyc - t0 <= mn + 12), 1'b1)
    end
    $display("test opc query done");
    dly <= 8'h05;
    ops_busy <= 1'b1;
    apb(1, OFF_ESE, 1); apb(1, OFF_SRE, 32'h20);
    apb(1, OFF_CMD, {29'h0, CMD_OPC});
    tick(SC / 2); `CHK(srq, 1'b0)
    tick(SC); `CHK(srq, 1'b0)
    ops_busy <= 1'b0;
    tick(4); `CHK(srq, 1'b1)
    apb(0, OFF_STB, 0); `CHK(q, 32'h60)
    apb(0, OFF_ESR, 0); `CHK(q, 32'h1)
    apb(0, OFF_ESR, 0); `CHK(q, 32'h0)
    $display("test opc command done");
    apb(1, OFF_SRE, 32'h10); apb(1, OFF_CMD, {29'h0, CMD_OPCQ});
    tick(SC + 10); `CHK(srq, 1'b1)
    apb(0, OFF_STB, 0); `CHK(q, 32'h50)
    $display("test message available done");
    @(posedge pclk);
    evt_set <= {NEVT{8'h81}}; err_push <= 1; err_code <= 8'h5a; log_push <= 1;
    @(posedge pclk);
    evt_set <= '0; err_push <= 0; log_push <= 0;
    apb(1, OFF_SRE, 32'h04); tick(2); `CHK(srq, 1'b1)
    apb(0, OFF_EVT + 12'h008, 0); `CHK(q, 32'h81)
    apb(1, OFF_CMD, {29'h0, CMD_CLS}); tick(2);
    `CHK(srq, 1'b0)
    for (int i = 0; i < NEVT; i++) begin
      apb(0, OFF_EVT + 12'(4 * i), 0); `CHK(q, 32'h0)
    end
    apb(0, OFF_ESR, 0); `CHK(q, 32'h0)
    apb(0, OFF_ERRQ, 0); `CHK(q[8], 1'b0)
    apb(0, OFF_STB, 0); `CHK(q, 32'h10)
    apb(0, OFF_LOG, 0); `CHK(q, 32'h1)
    apb(0, OFF_OQ, 0); `CHK(q, 32'h131)
    $display("test clear status done");
    apb(1, OFF_SRE, 0); apb(1, OFF_CMD, {29'h0, CMD_WAI});
    t0 = cyc;
    tick(2); `CHK(cmd_hold, 1'b1)
    apb(1, OFF_CMD, {29'h0, CMD_OPC}); `CHK(cyc - t0 >= SC, 1'b1)
    tick(2); `CHK(cmd_hold, 1'b0)
    $display("test wait done");
    on_mask <= 4'h1;
    apb(1, OFF_CMD, {29'h0, CMD_WAI}); tick(200);
    `CHK({meas_req, cmd_hold}, 2'b11)
    apb(0, OFF_SYNC, 0); `CHK(q[3], 1'b1)
    on_mask <= 4'h3;
    rst(); tick(1);
    `CHK({meas_req, cmd_hold, srq}, 3'b000)
    $display("test never complete done");
    summarize();
  end
endmodule
